// >>> shared/amcx_pkg.sv
/*
 Constants, register map and mode type shared by the crosspoint
 configuration device end and its serial-bus controller end.
 Assumes one 20 MHz clock in both ends.
*/
`default_nettype none
package amcx_pkg;
	// clock and serial-bus timing
	localparam int CLK_HZ = 20_000_000;
	localparam int SCL_HZ = 100_000;
	// quarter of an scl period, rounded down so the bus never runs slow
	localparam int SCL_QTR_CYCLES = CLK_HZ / (4 * SCL_HZ);
	// address when both select pins float
	localparam logic [6:0] I2C_ADDR_FLOAT = 7'h12;
	// strap level codes of the three-level select pins
	localparam logic [1:0] LVL_FLOAT = 2'h0;
	localparam logic [1:0] LVL_LOW = 2'h1;
	localparam logic [1:0] LVL_HIGH = 2'h2;
	localparam logic [1:0] LVL_RES = 2'h3;
	// register offsets
	localparam logic [7:0] REG_GEN = 8'h0A;
	localparam logic [7:0] REG_DP01 = 8'h10;
	localparam logic [7:0] REG_DP23 = 8'h11;
	localparam logic [7:0] REG_AUX = 8'h13;
	localparam logic [7:0] REG_DS = 8'h20;
	localparam logic [7:0] REG_US = 8'h21;
	localparam logic [7:0] REG_RESET = 8'h00;
	// field positions
	localparam int GEN_EQ_OVR_BIT = 4;
	localparam int GEN_FLIP_BIT = 2;
	localparam int GEN_UPPER_BIT = 1;
	localparam int GEN_LOWER_BIT = 0;
	localparam int AUX_MON_OFF_BIT = 7;
	localparam int AUX_ROUTE_LSB = 4;
	localparam int AUX_LANE1_OFF_BIT = 1;
	localparam int AUX_LANE0_OFF_BIT = 0;
	// auxiliary-to-sideband route codes
	localparam logic [1:0] ROUTE_AUTO = 2'h0;
	localparam logic [1:0] ROUTE_NORMAL = 2'h1;
	localparam logic [1:0] ROUTE_FLIPPED = 2'h2;

	typedef enum logic [1:0] {MODE_OFF, MODE_USB, MODE_USB_DP2, MODE_DP4} amcx_mode_t;
endpackage
`default_nettype wire

// >>> shared/amcx_i2c_if.sv
/*
 Two-wire serial link between controller and device.
 Assumes open-drain lines with pull-ups: a line is low while any enabled
 driver drives a low value.
*/
`timescale 1ns/100ps
`default_nettype none
interface amcx_i2c_if;
	logic m_scl_out;
	logic m_scl_oe;
	logic m_sda_out;
	logic m_sda_oe;
	logic d_sda_out;
	logic d_sda_oe;
	logic scl;
	logic sda;

	// wired-and of the open-drain drivers
	assign scl = !(m_scl_oe && !m_scl_out);
	assign sda = !((m_sda_oe && !m_sda_out) || (d_sda_oe && !d_sda_out));

	modport dev (input scl, input sda, output d_sda_out, output d_sda_oe);
	modport ctl (input scl, input sda, output m_scl_out, output m_scl_oe,
		output m_sda_out, output m_sda_oe);
endinterface
`default_nettype wire

// >>> design/amcx_device.sv
/*
 Device end: strap capture, serial-bus register slave, lane mode,
 orientation, equalization and auxiliary routing selection.
 Assumes all pins synchronous to clk_in and a controller keeping its
 duties on the auxiliary monitor and route fields.
*/
`timescale 1ns/100ps
`default_nettype none
module amcx_device
	import amcx_pkg::*;
(
	input wire logic clk_in,
	input wire logic nrst_in,
	amcx_i2c_if.dev bus,
	input wire logic i2c_sel_in,
	input wire logic [1:0] addr_select_hi_pin_in,
	input wire logic [1:0] addr_select_lo_pin_in,
	input wire logic upper_lane_config_pin_in,
	input wire logic lower_lane_config_pin_in,
	input wire logic flip_pin_in,
	input wire logic [1:0] downstream_eq_pins_in,
	input wire logic [1:0] upstream_eq_pins_in,
	input wire logic [1:0] display_eq_pins_in,
	output logic i2c_mode_out,
	output logic [6:0] i2c_addr_out,
	output amcx_mode_t mode_out,
	output logic flip_out,
	output logic [3:0] dp_lane_en_out,
	output logic [15:0] display_eq_out,
	output logic [7:0] downstream_eq_out,
	output logic [3:0] upstream_eq_out,
	output logic aux_monitor_on_out,
	output logic [1:0] aux_route_out
);
	typedef enum logic [2:0] {S_IDLE, S_ADDR, S_ACK_A, S_PTR, S_ACK_W, S_WDATA,
		S_RDATA, S_RACK} amcx_slv_t;

	logic straps_done, next_straps_done;
	logic [6:0] next_addr;
	logic next_i2c_mode;
	logic scl_q, sda_q, scl_p, sda_p;
	logic rise, fall, start, stop;
	amcx_slv_t state, next_state;
	logic [2:0] cnt, next_cnt;
	logic [7:0] sh, next_sh, ptr, next_ptr, rd_data, wr_data;
	logic drv, next_drv, rw, next_rw, wr_en;
	logic [7:0] gen, dp01, dp23, aux, ds, us;
	logic [7:0] next_gen, next_dp01, next_dp23, next_aux, next_ds, next_us;
	logic eq_ovr, mon_off;
	logic [15:0] eff_dp;
	logic [7:0] eff_ds;
	logic [3:0] eff_us;
	amcx_mode_t next_mode;
	logic next_flip;
	logic [3:0] next_lanes;
	logic [1:0] next_route;

	// two-bit pin code spreads evenly over the sixteen settings
	function automatic logic [3:0] pin_eq(input logic [1:0] p);
		return {p, p};
	endfunction

	// strap capture once, at the first edge after release
	always_comb
	begin
		next_straps_done = 1'b1;
		next_i2c_mode = straps_done ? i2c_mode_out : i2c_sel_in;
		next_addr = straps_done ? i2c_addr_out :
			7'(I2C_ADDR_FLOAT + {addr_select_hi_pin_in, 2'h0} + addr_select_lo_pin_in);
	end

	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			straps_done <= 1'b0;
			i2c_mode_out <= 1'b0;
			i2c_addr_out <= I2C_ADDR_FLOAT;
		end
		else
		begin
			straps_done <= next_straps_done;
			i2c_mode_out <= next_i2c_mode;
			i2c_addr_out <= next_addr;
		end
	end

	// line edges and bus conditions from the sampled lines
	assign rise = scl_q && !scl_p;
	assign fall = !scl_q && scl_p;
	assign start = scl_q && scl_p && sda_p && !sda_q;
	assign stop = scl_q && scl_p && !sda_p && sda_q;
	assign wr_data = {sh[6:0], sda_q};
	assign bus.d_sda_out = 1'b0;
	assign bus.d_sda_oe = drv;

	// slave sequencing: sample on scl rise, change sda only on scl fall
	always_comb
	begin
		next_state = state;
		next_cnt = cnt;
		next_sh = sh;
		next_ptr = ptr;
		next_drv = drv;
		next_rw = rw;
		wr_en = 1'b0;
		if (!i2c_mode_out)
		begin
			next_state = S_IDLE;
			next_drv = 1'b0;
		end
		else if (start)
		begin
			next_state = S_ADDR;
			next_cnt = 3'h0;
			next_drv = 1'b0;
		end
		else if (stop)
		begin
			next_state = S_IDLE;
			next_drv = 1'b0;
		end
		else if (rise)
		begin
			unique case (state)
				S_ADDR, S_PTR, S_WDATA:
				begin
					next_sh = wr_data;
					next_cnt = 3'(cnt + 3'h1);
					if (cnt == 3'h7)
					begin
						if (state == S_ADDR)
						begin
							next_rw = sda_q;
							next_state = (sh[6:0] == i2c_addr_out) ? S_ACK_A : S_IDLE;
						end
						else if (state == S_PTR)
						begin
							next_ptr = wr_data;
							next_state = S_ACK_W;
						end
						else
						begin
							wr_en = 1'b1;
							next_ptr = 8'(ptr + 8'h01);
							next_state = S_ACK_W;
						end
					end
				end
				S_RDATA:
				begin
					next_cnt = 3'(cnt + 3'h1);
					if (cnt == 3'h7)
					begin
						next_state = S_RACK;
						next_ptr = 8'(ptr + 8'h01);
					end
				end
				S_RACK:
				begin
					// a not-acknowledge ends the read burst
					next_state = sda_q ? S_IDLE : S_RDATA;
					next_sh = rd_data;
					next_cnt = 3'h0;
				end
				S_IDLE, S_ACK_A, S_ACK_W: ;
			endcase
		end
		else if (fall)
		begin
			unique case (state)
				S_ACK_A:
					if (!drv)
						next_drv = 1'b1;
					else if (rw)
					begin
						next_state = S_RDATA;
						next_drv = !rd_data[7];
						next_sh = {rd_data[6:0], 1'b0};
						next_cnt = 3'h0;
					end
					else
					begin
						next_state = S_PTR;
						next_drv = 1'b0;
						next_cnt = 3'h0;
					end
				S_ACK_W:
					if (!drv)
						next_drv = 1'b1;
					else
					begin
						next_state = S_WDATA;
						next_drv = 1'b0;
						next_cnt = 3'h0;
					end
				S_RDATA:
				begin
					next_drv = !sh[7];
					next_sh = {sh[6:0], 1'b0};
				end
				S_RACK, S_IDLE, S_ADDR, S_PTR, S_WDATA: next_drv = 1'b0;
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			scl_p <= 1'b1;
			sda_p <= 1'b1;
			state <= S_IDLE;
			cnt <= 3'h0;
			sh <= 8'h00;
			ptr <= 8'h00;
			drv <= 1'b0;
			rw <= 1'b0;
		end
		else
		begin
			scl_q <= bus.scl;
			sda_q <= bus.sda;
			scl_p <= scl_q;
			sda_p <= sda_q;
			state <= next_state;
			cnt <= next_cnt;
			sh <= next_sh;
			ptr <= next_ptr;
			drv <= next_drv;
			rw <= next_rw;
		end
	end

	// effective equalization: registers only under override in bus mode
	assign eq_ovr = i2c_mode_out && gen[GEN_EQ_OVR_BIT];
	assign mon_off = i2c_mode_out && aux[AUX_MON_OFF_BIT];
	assign eff_dp = eq_ovr ? {dp23, dp01} : {4{pin_eq(display_eq_pins_in)}};
	assign eff_ds = eq_ovr ? ds : {2{pin_eq(downstream_eq_pins_in)}};
	assign eff_us = eq_ovr ? us[3:0] : pin_eq(upstream_eq_pins_in);

	// read data; equalization fields show what is in effect
	always_comb
	begin
		unique case (ptr)
			REG_GEN: rd_data = gen;
			REG_DP01: rd_data = eff_dp[7:0];
			REG_DP23: rd_data = eff_dp[15:8];
			REG_AUX: rd_data = aux;
			REG_DS: rd_data = eff_ds;
			REG_US: rd_data = {4'h0, eff_us};
			default: rd_data = 8'h00;
		endcase
	end

	// register writes; unmapped offsets are ignored
	always_comb
	begin
		next_gen = gen;
		next_dp01 = dp01;
		next_dp23 = dp23;
		next_aux = aux;
		next_ds = ds;
		next_us = us;
		if (wr_en)
		begin
			unique case (ptr)
				REG_GEN: next_gen = wr_data;
				REG_DP01: next_dp01 = wr_data;
				REG_DP23: next_dp23 = wr_data;
				REG_AUX: next_aux = wr_data;
				REG_DS: next_ds = wr_data;
				REG_US: next_us = {4'h0, wr_data[3:0]};
				default: ;
			endcase
		end
	end

	// mode, orientation, lanes and routing
	always_comb
	begin
		logic up, lo;
		up = i2c_mode_out ? gen[GEN_UPPER_BIT] : upper_lane_config_pin_in;
		lo = i2c_mode_out ? gen[GEN_LOWER_BIT] : lower_lane_config_pin_in;
		next_flip = i2c_mode_out ? gen[GEN_FLIP_BIT] : flip_pin_in;
		unique case ({up, lo})
			2'h1: next_mode = MODE_USB;
			2'h3: next_mode = MODE_USB_DP2;
			2'h2: next_mode = MODE_DP4;
			default: next_mode = MODE_OFF;
		endcase
		// MODE_DP4 lights all four lanes, MODE_USB_DP2 lanes 0 and 1; no monitoring involved in pin mode
		unique case (next_mode)
			MODE_DP4: next_lanes = 4'hF;
			MODE_USB_DP2: next_lanes = 4'h3;
			default: next_lanes = 4'h0;
		endcase
		if (mon_off)
			next_lanes = next_lanes & ~{2'h0, aux[AUX_LANE1_OFF_BIT], aux[AUX_LANE0_OFF_BIT]};
		next_route = mon_off ? aux[AUX_ROUTE_LSB +: 2] : ROUTE_AUTO;
	end

	// main-link polarity and lane order pass through; no correction here
	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			gen <= REG_RESET;
			dp01 <= REG_RESET;
			dp23 <= REG_RESET;
			aux <= REG_RESET;
			ds <= REG_RESET;
			us <= REG_RESET;
			mode_out <= MODE_OFF;
			flip_out <= 1'b0;
			dp_lane_en_out <= 4'h0;
			display_eq_out <= 16'h0000;
			downstream_eq_out <= 8'h00;
			upstream_eq_out <= 4'h0;
			aux_monitor_on_out <= 1'b1;
			aux_route_out <= ROUTE_AUTO;
		end
		else
		begin
			gen <= next_gen;
			dp01 <= next_dp01;
			dp23 <= next_dp23;
			aux <= next_aux;
			ds <= next_ds;
			us <= next_us;
			mode_out <= next_mode;
			flip_out <= next_flip;
			dp_lane_en_out <= next_lanes;
			display_eq_out <= eff_dp;
			downstream_eq_out <= eff_ds;
			upstream_eq_out <= eff_us;
			aux_monitor_on_out <= !mon_off;
			aux_route_out <= next_route;
		end
	end
endmodule
`default_nettype wire

// >>> design/amcx_controller.sv
/*
 Controller end: single-register write or read over the two-wire link.
 Write: start, address+W, offset, data, stop. Read: start, address+W,
 offset, repeated start, address+R, one byte with not-acknowledge, stop.
 Assumes the device address matches DEV_ADDR.
*/
`timescale 1ns/100ps
`default_nettype none
module amcx_controller
	import amcx_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = I2C_ADDR_FLOAT,
	parameter int QTR_CYCLES = SCL_QTR_CYCLES
)
(
	input wire logic clk_in,
	input wire logic nrst_in,
	amcx_i2c_if.ctl bus,
	input wire logic cmd_valid_in,
	input wire logic cmd_read_in,
	input wire logic [7:0] cmd_reg_in,
	input wire logic [7:0] cmd_data_in,
	output logic cmd_ready_out,
	output logic rsp_valid_out,
	output logic [7:0] rsp_data_out,
	output logic rsp_nack_out
);
	typedef enum logic [1:0] {C_IDLE, C_START, C_BIT, C_STOP} amcx_ctl_t;

	amcx_ctl_t state, next_state;
	logic [15:0] tmr, next_tmr;
	logic [1:0] q, next_q;
	logic [3:0] bitn, next_bitn;
	logic [2:0] idx, next_idx;
	logic [7:0] sh, next_sh, reg_q, next_reg_q, dat_q, next_dat_q;
	logic rd_q, next_rd_q, nack, next_nack;
	logic next_rsp_valid, next_rsp_nack;
	logic [7:0] next_rsp_data, tx_byte;
	logic tick, reading, scl_lvl, sda_lvl;

	assign tick = (tmr == 16'(QTR_CYCLES - 1));
	assign reading = (idx == 3'h4);
	assign cmd_ready_out = (state == C_IDLE);
	assign bus.m_scl_out = 1'b0;
	assign bus.m_sda_out = 1'b0;

	// byte sequence of one transfer
	always_comb
	begin
		unique case (idx)
			3'h0: tx_byte = {DEV_ADDR, 1'b0};
			3'h1: tx_byte = reg_q;
			3'h2: tx_byte = dat_q;
			3'h3: tx_byte = {DEV_ADDR, 1'b1};
			default: tx_byte = 8'h00;
		endcase
	end

	// line levels: data changes while scl is low, sampled while high
	always_comb
	begin
		unique case (state)
			C_IDLE:
			begin
				scl_lvl = 1'b1;
				sda_lvl = 1'b1;
			end
			C_START:
			begin
				scl_lvl = (q != 2'h0);
				sda_lvl = (q < 2'h2);
			end
			C_BIT:
			begin
				scl_lvl = (q >= 2'h2);
				sda_lvl = (bitn < 4'h8 && !reading) ? sh[7] : 1'b1;
			end
			C_STOP:
			begin
				scl_lvl = (q != 2'h0);
				sda_lvl = (q >= 2'h2);
			end
		endcase
	end

	// transfer sequencing in quarter-bit steps
	always_comb
	begin
		next_state = state;
		next_tmr = (state == C_IDLE || tick) ? 16'h0000 : 16'(tmr + 16'h0001);
		next_q = q;
		next_bitn = bitn;
		next_idx = idx;
		next_sh = sh;
		next_reg_q = reg_q;
		next_dat_q = dat_q;
		next_rd_q = rd_q;
		next_nack = nack;
		next_rsp_valid = 1'b0;
		next_rsp_data = rsp_data_out;
		next_rsp_nack = rsp_nack_out;
		if (state == C_IDLE)
		begin
			if (cmd_valid_in)
			begin
				next_state = C_START;
				next_q = 2'h0;
				next_idx = 3'h0;
				next_reg_q = cmd_reg_in;
				next_dat_q = cmd_data_in;
				next_rd_q = cmd_read_in;
				next_nack = 1'b0;
			end
		end
		else if (tick)
		begin
			next_q = 2'(q + 2'h1);
			unique case (state)
				C_START:
					if (q == 2'h3)
					begin
						next_state = C_BIT;
						next_bitn = 4'h0;
						next_sh = tx_byte;
					end
				C_BIT:
					if (q == 2'h2)
					begin
						if (bitn < 4'h8 && reading)
							next_sh = {sh[6:0], bus.sda};
						else if (bitn == 4'h8 && !reading)
							next_nack = bus.sda;
					end
					else if (q == 2'h3)
					begin
						next_bitn = 4'(bitn + 4'h1);
						if (bitn < 4'h8 && !reading)
							next_sh = {sh[6:0], 1'b0};
						if (bitn == 4'h8)
						begin
							next_bitn = 4'h0;
							// keep sh on the way to stop: it carries the read byte
							if (nack || reading || idx == 3'h2)
								next_state = C_STOP;
							else if (idx == 3'h1 && rd_q)
							begin
								next_state = C_START;
								next_idx = 3'h3;
							end
							else
							begin
								next_idx = 3'(idx + 3'h1);
								next_sh = (idx == 3'h0) ? reg_q : (idx == 3'h1) ? dat_q : 8'h00;
							end
						end
					end
				C_STOP:
					if (q == 2'h3)
					begin
						next_state = C_IDLE;
						next_rsp_valid = 1'b1;
						next_rsp_data = sh;
						next_rsp_nack = nack;
					end
				C_IDLE: ;
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			state <= C_IDLE;
			tmr <= 16'h0000;
			q <= 2'h0;
			bitn <= 4'h0;
			idx <= 3'h0;
			sh <= 8'h00;
			reg_q <= 8'h00;
			dat_q <= 8'h00;
			rd_q <= 1'b0;
			nack <= 1'b0;
			rsp_valid_out <= 1'b0;
			rsp_data_out <= 8'h00;
			rsp_nack_out <= 1'b0;
			bus.m_scl_oe <= 1'b0;
			bus.m_sda_oe <= 1'b0;
		end
		else
		begin
			state <= next_state;
			tmr <= next_tmr;
			q <= next_q;
			bitn <= next_bitn;
			idx <= next_idx;
			sh <= next_sh;
			reg_q <= next_reg_q;
			dat_q <= next_dat_q;
			rd_q <= next_rd_q;
			nack <= next_nack;
			rsp_valid_out <= next_rsp_valid;
			rsp_data_out <= next_rsp_data;
			rsp_nack_out <= next_rsp_nack;
			// monitor-off is written by the user through this port
			bus.m_scl_oe <= !scl_lvl;
			bus.m_sda_oe <= !sda_lvl;
		end
	end
endmodule
`default_nettype wire

// >>> bench/amcx_monitor.sv
/*
 Checker for the serial link and the device's mode outputs.
 Assumes the bench connects interface and device signals by name.
*/
`timescale 1ns/100ps
`default_nettype none
module amcx_monitor
	import amcx_pkg::*;
(
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic scl,
	input wire logic d_sda_oe,
	input wire logic [1:0] addr_select_hi_pin_in,
	input wire logic [1:0] addr_select_lo_pin_in,
	input wire logic upper_lane_config_pin_in,
	input wire logic lower_lane_config_pin_in,
	input wire logic flip_pin_in,
	input wire logic [1:0] display_eq_pins_in,
	input wire logic i2c_mode_out,
	input wire logic [6:0] i2c_addr_out,
	input wire amcx_mode_t mode_out,
	input wire logic flip_out,
	input wire logic [3:0] dp_lane_en_out,
	input wire logic [15:0] display_eq_out,
	input wire logic aux_monitor_on_out,
	input wire logic [1:0] aux_route_out
);
	logic [3:0] cyc;
	logic pin_ok;
	// cycles since reset release, saturating; straps settle by the third
	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
			cyc <= 4'h0;
		else if (cyc != 4'hF)
			cyc <= cyc + 4'h1;
	end
	assign pin_ok = !i2c_mode_out && (cyc > 4'h3);
	// pin decode kept apart from the design's own logic
	function automatic amcx_mode_t pin_mode(input logic u, input logic l);
		return ({u, l} == 2'h1) ? MODE_USB : ({u, l} == 2'h3) ? MODE_USB_DP2 :
			({u, l} == 2'h2) ? MODE_DP4 : MODE_OFF;
	endfunction
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!nrst_in);
	// strap capture, mode decode, lane, flip, eq, routing and link relations
	property p_strap_stable;
		cyc > 4'h3 |-> $stable(i2c_mode_out) && $stable(i2c_addr_out);
	endproperty
	a_strap_stable: assert property (p_strap_stable) else $error("strap result moved");
	property p_addr;
		cyc == 4'h3 |-> i2c_addr_out == I2C_ADDR_FLOAT + {3'h0, addr_select_hi_pin_in, 2'h0}
			+ {5'h0, addr_select_lo_pin_in};
	endproperty
	a_addr: assert property (p_addr) else $error("address not from straps");
	property p_pin_mode;
		pin_ok |-> mode_out == pin_mode($past(upper_lane_config_pin_in),
			$past(lower_lane_config_pin_in));
	endproperty
	a_pin_mode: assert property (p_pin_mode) else $error("pin mode decode wrong");
	property p_pin_lanes;
		pin_ok |-> dp_lane_en_out == ((mode_out == MODE_DP4) ? 4'hF :
			(mode_out == MODE_USB_DP2) ? 4'h3 : 4'h0);
	endproperty
	a_pin_lanes: assert property (p_pin_lanes) else $error("pin mode lanes wrong");
	property p_flip;
		pin_ok |-> flip_out == $past(flip_pin_in);
	endproperty
	a_flip: assert property (p_flip) else $error("flip not from pin");
	property p_pin_eq;
		pin_ok |-> display_eq_out == {8{$past(display_eq_pins_in)}};
	endproperty
	a_pin_eq: assert property (p_pin_eq) else $error("pin eq not applied");
	property p_route;
		aux_route_out != ROUTE_AUTO |-> i2c_mode_out && !aux_monitor_on_out && aux_route_out != 2'h3;
	endproperty
	a_route: assert property (p_route) else $error("manual route while monitoring");
	property p_monitor;
		aux_monitor_on_out && mode_out == MODE_DP4 |-> dp_lane_en_out == 4'hF;
	endproperty
	a_monitor: assert property (p_monitor) else $error("lane off bit acted while monitoring");
	property p_sda_turn;
		$changed(d_sda_oe) |-> !scl;
	endproperty
	a_sda_turn: assert property (p_sda_turn) else $error("device moved sda with scl high");
	property p_pin_quiet;
		pin_ok |-> !d_sda_oe;
	endproperty
	a_pin_quiet: assert property (p_pin_quiet) else $error("device drove link in pin mode");
	// main scenarios reached
	c_dp4_bus: cover property (i2c_mode_out && mode_out == MODE_DP4);
	c_route_flip: cover property (aux_route_out == ROUTE_FLIPPED);
	c_ack: cover property ($rose(d_sda_oe));
	c_usb_pin: cover property (pin_ok && mode_out == MODE_USB);
endmodule
`default_nettype wire

// >>> bench/tb.sv
/*
 Bench joining controller and device through the link interface.
 Assumes a 20 MHz clock and shortened serial quarters.
*/
`timescale 1ns/100ps
`default_nettype none
module tb
	import amcx_pkg::*;
;
	typedef struct packed {logic u; logic l; logic f; logic [1:0] dp; logic [1:0] ds;
		logic [1:0] us; amcx_mode_t md; logic [3:0] ln;} amcx_row_t;
	amcx_row_t rows [6] = '{'{1'h0, 1'h1, 1'h0, 2'h0, 2'h1, 2'h2, MODE_USB, 4'h0},
		'{1'h0, 1'h1, 1'h1, 2'h3, 2'h0, 2'h1, MODE_USB, 4'h0},
		'{1'h1, 1'h1, 1'h0, 2'h1, 2'h2, 2'h3, MODE_USB_DP2, 4'h3},
		'{1'h1, 1'h1, 1'h1, 2'h2, 2'h3, 2'h0, MODE_USB_DP2, 4'h3},
		'{1'h1, 1'h0, 1'h1, 2'h3, 2'h3, 2'h3, MODE_DP4, 4'hF},
		'{1'h0, 1'h0, 1'h0, 2'h1, 2'h1, 2'h1, MODE_OFF, 4'h0}};
	logic [7:0] aux_wr [3] = '{8'h11, 8'h91, 8'hA2};
	logic [1:0] aux_rt [3] = '{ROUTE_AUTO, ROUTE_NORMAL, ROUTE_FLIPPED};
	logic [3:0] aux_ln [3] = '{4'hF, 4'hE, 4'hD};
	logic clk_in = 1'h0;
	logic nrst_in = 1'h0;
	logic sel = 1'h0, up = 1'h0, lo = 1'h0, flip = 1'h0;
	logic [1:0] a_hi = 2'h0, a_lo = 2'h0, dpeq = 2'h0, dseq = 2'h0, useq = 2'h0;
	logic cv = 1'h0, crd = 1'h0;
	logic [7:0] creg = 8'h00, cdat = 8'h00;
	logic m_i2c, m_flip, m_mon, cready, rvalid, rnack;
	logic [6:0] m_addr;
	amcx_mode_t m_mode;
	logic [3:0] m_lanes, m_us;
	logic [15:0] m_dp;
	logic [7:0] m_ds, rdata;
	logic [1:0] m_route;
	int errors = 0, checks = 0, cyc = 0;
	amcx_i2c_if link ();
	amcx_device amcx_device_i (.clk_in(clk_in), .nrst_in(nrst_in), .bus(link.dev),
		.i2c_sel_in(sel), .addr_select_hi_pin_in(a_hi), .addr_select_lo_pin_in(a_lo),
		.upper_lane_config_pin_in(up), .lower_lane_config_pin_in(lo), .flip_pin_in(flip),
		.downstream_eq_pins_in(dseq), .upstream_eq_pins_in(useq), .display_eq_pins_in(dpeq),
		.i2c_mode_out(m_i2c), .i2c_addr_out(m_addr), .mode_out(m_mode), .flip_out(m_flip),
		.dp_lane_en_out(m_lanes), .display_eq_out(m_dp), .downstream_eq_out(m_ds),
		.upstream_eq_out(m_us), .aux_monitor_on_out(m_mon), .aux_route_out(m_route));
	// short quarters keep each transfer a few hundred cycles
	amcx_controller #(.DEV_ADDR(I2C_ADDR_FLOAT), .QTR_CYCLES(4)) amcx_controller_i (
		.clk_in(clk_in), .nrst_in(nrst_in), .bus(link.ctl), .cmd_valid_in(cv),
		.cmd_read_in(crd), .cmd_reg_in(creg), .cmd_data_in(cdat), .cmd_ready_out(cready),
		.rsp_valid_out(rvalid), .rsp_data_out(rdata), .rsp_nack_out(rnack));
	amcx_monitor amcx_monitor_i (.clk_in(clk_in), .nrst_in(nrst_in), .scl(link.scl),
		.d_sda_oe(link.d_sda_oe), .addr_select_hi_pin_in(a_hi), .addr_select_lo_pin_in(a_lo),
		.upper_lane_config_pin_in(up), .lower_lane_config_pin_in(lo), .flip_pin_in(flip),
		.display_eq_pins_in(dpeq), .i2c_mode_out(m_i2c), .i2c_addr_out(m_addr),
		.mode_out(m_mode), .flip_out(m_flip), .dp_lane_en_out(m_lanes), .display_eq_out(m_dp),
		.aux_monitor_on_out(m_mon), .aux_route_out(m_route));
	// 50 ns clock
	initial
	begin
		forever #25 clk_in = !clk_in;
	end
	task automatic summarize();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		checks++;
		if (g !== e)
		begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// reset for four cycles with the given straps, then let them settle
	task automatic do_rst(input logic s, input logic [1:0] h, input logic [1:0] l);
		@(posedge clk_in);
		nrst_in <= 1'h0;
		sel <= s;
		a_hi <= h;
		a_lo <= l;
		repeat (4) @(posedge clk_in);
		nrst_in <= 1'h1;
		repeat (4) @(posedge clk_in);
		@(negedge clk_in);
	endtask
	// one register transfer; a missing response counts as a mismatch
	task automatic xfer(input logic rd, input logic [7:0] r, input logic [7:0] d);
		int n;
		@(posedge clk_in);
		cv <= 1'h1;
		crd <= rd;
		creg <= r;
		cdat <= d;
		@(posedge clk_in);
		cv <= 1'h0;
		@(negedge clk_in);
		chk("ready while busy", 16'h0, {15'h0, cready});
		for (n = 0; n < 4000 && rvalid !== 1'h1; n++)
			@(negedge clk_in);
		chk("response and ready", 16'h3, {14'h0, cready, rvalid});
	endtask
	// cuts a hang short
	always @(posedge clk_in)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			errors++;
			summarize();
		end
	end
	initial
	begin
		do_rst(1'h0, LVL_FLOAT, LVL_FLOAT);
		chk("i2c mode", 16'h0, {15'h0, m_i2c});
		foreach (rows[i])
		begin
			@(posedge clk_in);
			{up, lo, flip, dpeq, dseq, useq} <= rows[i][14:6];
			repeat (2) @(posedge clk_in);
			@(negedge clk_in);
			chk("mode", 16'(rows[i].md), 16'(m_mode));
			chk("lanes", 16'(rows[i].ln), 16'(m_lanes));
			chk("flip", 16'(rows[i].f), 16'(m_flip));
			chk("display eq", {8{rows[i].dp}}, m_dp);
			chk("usb eq", {4'h0, {2{rows[i].us}}, {4{rows[i].ds}}}, {4'h0, m_us, m_ds});
		end
		$display("test pin table done");
		do_rst(1'h1, LVL_FLOAT, LVL_FLOAT);
		@(posedge clk_in);
		dpeq <= 2'h2;
		dseq <= 2'h3;
		useq <= 2'h2;
		chk("i2c mode", 16'h1, {15'h0, m_i2c});
		chk("address", 16'h12, 16'(m_addr));
		xfer(1'h0, REG_GEN, 8'h02);
		chk("bus mode", 16'(MODE_DP4), 16'(m_mode));
		xfer(1'h0, REG_DP01, 8'h55);
		xfer(1'h0, REG_DP23, 8'h55);
		xfer(1'h0, REG_DS, 8'h66);
		xfer(1'h0, REG_US, 8'h08);
		chk("eq from pins", 16'hAAAA, m_dp);
		chk("usb eq from pins", 16'h0AFF, {4'h0, m_us, m_ds});
		xfer(1'h1, REG_DS, 8'h00);
		chk("read ds pins", 16'hFF, 16'(rdata));
		xfer(1'h0, REG_GEN, 8'h12);
		chk("display eq", 16'h5555, m_dp);
		chk("ds eq", 16'h66, 16'(m_ds));
		chk("us eq", 16'h8, 16'(m_us));
		xfer(1'h1, REG_DS, 8'h00);
		chk("read ds", 16'h66, 16'(rdata));
		xfer(1'h1, REG_US, 8'h00);
		chk("read us", 16'h08, 16'(rdata));
		xfer(1'h1, 8'h30, 8'h00);
		chk("read unmapped", 16'h0, {7'h0, rnack, rdata});
		for (int i = 0; i < 3; i++)
		begin
			xfer(1'h0, REG_AUX, aux_wr[i]);
			chk("route", 16'(aux_rt[i]), 16'(m_route));
			chk("lanes", 16'(aux_ln[i]), 16'(m_lanes));
			chk("monitor", 16'(i == 0), {15'h0, m_mon});
		end
		$display("test bus mode done");
		do_rst(1'h1, LVL_LOW, LVL_HIGH);
		@(posedge clk_in);
		sel <= 1'h0;
		chk("address", 16'h18, 16'(m_addr));
		xfer(1'h0, REG_GEN, 8'h02);
		chk("nack", 16'h1, {15'h0, rnack});
		chk("i2c mode held", 16'h1, {15'h0, m_i2c});
		$display("test strap done");
		summarize();
	end
endmodule
`default_nettype wire
